/* include/tsa_pkg.sv */
// Purpose: Shared constants and types for the time slot assigner
// Assumes: 100 MHz system clock samples every outside pin
// Notes:   Register offsets are APB byte addresses
package tsa_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] TSA_OFS_CTRL   = 12'h000;
   localparam logic [11:0] TSA_OFS_STATUS = 12'h004;
   localparam logic [11:0] TSA_OFS_SLOTS  = 12'h008;

   localparam int unsigned TSA_CTRL_PORT_EN_BIT = 0;
   localparam int unsigned TSA_CTRL_ABORT_BIT   = 1;
   localparam int unsigned TSA_SLOTS_RX_LSB     = 8;
   localparam int unsigned TSA_SLOTS_LINE_LSB   = 16;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic        TSA_PORT_EN_RST = 1'b1;
   localparam logic        TSA_PD_RST      = 1'b1;
   localparam logic [5:0]  TSA_SLOT_RST    = 6'h00;
   localparam logic [2:0]  TSA_LINE_RST    = 3'h0;
   localparam logic [2:0]  TSA_WORD_LAST   = 3'h7;
   localparam logic [1:0]  TSA_ACK_LAST    = 2'h2;
   localparam logic [9:0]  TSA_POS_MAX     = 10'h3FF;
   localparam logic [9:0]  TSA_POS_ZERO    = 10'h000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TSA_MODE_BOTH = 2'b00,
      TSA_MODE_TX   = 2'b01,
      TSA_MODE_RX   = 2'b10,
      TSA_MODE_IDLE = 2'b11
   } tsa_mode_t;

   typedef enum logic [1:0] {
      TSA_ACK_IDLE = 2'b00,
      TSA_ACK_WAIT = 2'b01,
      TSA_ACK_LOW  = 2'b11
   } tsa_ack_t;

   typedef struct packed {
      logic [2:0] line_ctrl;
      logic [5:0] rx_slot;
      logic [5:0] tx_slot;
   } tsa_cfg_t;

   // Bit position inside the frame falls within the given slot
   function automatic logic tsa_slot_hit(input logic [9:0] pos, input logic [5:0] slot);
      tsa_slot_hit = (pos[9] == 1'b0) && (pos[8:3] == slot);
   endfunction : tsa_slot_hit

endpackage : tsa_pkg

/* hw/tsa_slot_assigner.sv */
// Purpose: Time slot assigner for one per-channel codec
// Assumes: All pins except the APB ones are asynchronous to i_clk and pass two flops first
// Notes:   P_ADDRESSED selects the addressed or the single-select variant
//
// What this block does
// - Acknowledge low three data clocks after next tx frame sync, released next sync.
// - Addressed variant acknowledges only when the word address matched.
// - Acknowledge only pulls low, otherwise released to the pull-up.
// - Only rising frame sync edges matter; they fix where slot zero starts.
// - Data clock edge seeing the sync rise is the sign bit of slot zero.
// - Addressed variant times both directions from data clock A.
// - Single-select variant: tx on clock A, rx on clock B, unrelated clocks.
// - Each enable is high exactly eight data clocks, on a slot boundary.
// - Six slot bits count eight-clock slots from frame sync to enable.
// - Words arrive first bit first: mode, slot bits; line bits, address.
// - Unreceived or mismatched word loads nothing and changes no output.
// - Addressed modes: both, tx, rx, or idle with counters stopped.
// - Single-select modes: both, tx, rx with power up, or power down.
// - Every effect of an accepted word waits for the next tx frame sync.
// - Single-select variant: hook status keeps following the old tx slot while tx is disabled.
// - Eight bits shift into both words on falling serial clock with select high.
// - Addressed variant: last five select bits compare to the id pins; first three drive line bits.
// - Ring clear input forces line control bit two to zero.
// - Accepted data loads at frame sync; all units then become ready again.
//
// Implementation choices: the APB interface to the registers and the register addresses.
module tsa_slot_assigner
   import tsa_pkg::*;
#(
   parameter bit P_ADDRESSED = 1'b1
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   // Serial programming port
   input  wire logic        i_serial_clk,
   input  wire logic        i_group_select,
   input  wire logic        i_slot_word_in,
   input  wire logic        i_select_word_in,
   input  wire logic [4:0]  i_hardwired_id,
   output logic             o_accept_ack_o,
   output logic             o_accept_ack_oe,
   // Frame timing
   input  wire logic        i_data_clock_a,
   input  wire logic        i_data_clock_b,
   input  wire logic        i_tx_frame_sync,
   input  wire logic        i_rx_frame_sync,
   output logic             o_tx_slot_enable,
   output logic             o_rx_slot_enable,
   // Supervision
   input  wire logic        i_ring_clear_input,
   input  wire logic        i_hook_sense_in,
   output logic [2:0]       o_line_control_bits,
   output logic             o_power_down_out,
   output logic             o_hook_status_out_o,
   output logic             o_hook_status_out_oe
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int unsigned NPIN = 15;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1_reg;
   logic [NPIN-1:0] pin_s2_reg;
   logic [2:0]      edge_d_reg;

   assign pin_raw = {i_hardwired_id, i_hook_sense_in, i_ring_clear_input, i_rx_frame_sync,
                     i_tx_frame_sync, i_data_clock_b, i_data_clock_a, i_select_word_in,
                     i_slot_word_in, i_group_select, i_serial_clk};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               pin_s1_reg[gi] <= 1'b0;
               pin_s2_reg[gi] <= 1'b0;
            end else begin
               pin_s1_reg[gi] <= pin_raw[gi];
               pin_s2_reg[gi] <= pin_s1_reg[gi];
            end
         end
      end
   endgenerate

   logic       sclk_s, cs_s, sdi_s, sel_s, dca_s, dcb_s, fst_s, fsr_s, ring_s, hook_s;
   logic [4:0] id_s;
   assign {id_s, hook_s, ring_s, fsr_s, fst_s, dcb_s, dca_s, sel_s, sdi_s, cs_s, sclk_s} = pin_s2_reg;

   // Edges are taken from the second stage onward only
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         edge_d_reg <= 3'h0;
      end else begin
         edge_d_reg <= {dcb_s, dca_s, sclk_s};
      end
   end

   logic sclk_fall, dca_rise, dcb_rise, rx_dc_rise;
   assign sclk_fall  = edge_d_reg[0] & ~sclk_s;
   assign dca_rise   = ~edge_d_reg[1] & dca_s;
   assign dcb_rise   = ~edge_d_reg[2] & dcb_s;
   assign rx_dc_rise = P_ADDRESSED ? dca_rise : dcb_rise;

   // ----------------------------------------------------------------
   // Frame sync edges sampled on data clock rises
   // ----------------------------------------------------------------
   logic fst_prev_reg, fsr_prev_reg;
   logic tx_fs_start, rx_fs_start;
   logic rx_fs_level;

   assign rx_fs_level = fsr_s;
   assign tx_fs_start = dca_rise & fst_s & ~fst_prev_reg;
   assign rx_fs_start = rx_dc_rise & rx_fs_level & ~fsr_prev_reg;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fst_prev_reg <= 1'b0;
         fsr_prev_reg <= 1'b0;
      end else begin
         if (dca_rise) fst_prev_reg <= fst_s;
         if (rx_dc_rise) fsr_prev_reg <= rx_fs_level;
      end
   end

   // ----------------------------------------------------------------
   // Serial port
   // ----------------------------------------------------------------
   logic [7:0] slot_sh_reg, sel_sh_reg, slot_hold_reg, sel_hold_reg;
   logic [2:0] bit_cnt_reg;
   logic       pending_reg, port_en_reg, abort_wr;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         slot_sh_reg   <= 8'h00;
         sel_sh_reg    <= 8'h00;
         slot_hold_reg <= 8'h00;
         sel_hold_reg  <= 8'h00;
         bit_cnt_reg   <= 3'h0;
      end else if (!cs_s || !port_en_reg) begin
         bit_cnt_reg <= 3'h0;                                          // Dropping select aborts a word
      end else if (sclk_fall) begin
         slot_sh_reg <= {slot_sh_reg[6:0], sdi_s};
         sel_sh_reg  <= {sel_sh_reg[6:0], sel_s};
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == TSA_WORD_LAST) begin
            slot_hold_reg <= {slot_sh_reg[6:0], sdi_s};
            sel_hold_reg  <= {sel_sh_reg[6:0], sel_s};
         end
      end
   end

   logic word_done;
   assign word_done = cs_s & port_en_reg & sclk_fall & (bit_cnt_reg == TSA_WORD_LAST);

   // A word finishing in the frame sync cycle stays pending; set beats clear
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pending_reg <= 1'b0;
      end else if (word_done) begin
         pending_reg <= 1'b1;
      end else if (tx_fs_start || abort_wr) begin
         pending_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Decode at transmit frame sync
   // ----------------------------------------------------------------
   tsa_mode_t mode;
   logic      id_match, accept;
   assign mode     = tsa_mode_t'(slot_hold_reg[7:6]);
   assign id_match = P_ADDRESSED ? (sel_hold_reg[4:0] == id_s) : 1'b1;
   assign accept   = tx_fs_start & pending_reg & id_match;

   tsa_cfg_t cfg_reg;
   logic     tx_on_reg, rx_on_reg, run_reg, pd_reg;
   logic     ld_tx, ld_rx;

   always_comb begin
      ld_tx = 1'b0;
      ld_rx = 1'b0;
      case (mode)
         TSA_MODE_BOTH: begin ld_tx = 1'b1; ld_rx = 1'b1; end
         TSA_MODE_TX:   ld_tx = 1'b1;
         TSA_MODE_RX:   ld_rx = 1'b1;
         default:       ;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cfg_reg   <= '{line_ctrl: TSA_LINE_RST, rx_slot: TSA_SLOT_RST, tx_slot: TSA_SLOT_RST};
         tx_on_reg <= 1'b0;
         rx_on_reg <= 1'b0;
         run_reg   <= 1'b0;
         pd_reg    <= TSA_PD_RST;
      end else begin
         if (accept) begin
            if (ld_tx) cfg_reg.tx_slot <= slot_hold_reg[5:0];
            if (ld_rx) cfg_reg.rx_slot <= slot_hold_reg[5:0];
            if (ld_tx || ld_rx) begin
               tx_on_reg <= tx_on_reg | ld_tx | (P_ADDRESSED & ld_rx & ld_tx);
               rx_on_reg <= rx_on_reg | ld_rx | (P_ADDRESSED & ld_tx);
               run_reg   <= 1'b1;
               pd_reg    <= 1'b1;
            end else begin
               tx_on_reg <= 1'b0;
               rx_on_reg <= P_ADDRESSED ? 1'b0 : rx_on_reg;
               run_reg   <= P_ADDRESSED ? 1'b0 : run_reg;              // Single variant keeps hook timing
               pd_reg    <= P_ADDRESSED ? pd_reg : 1'b0;
            end
            if (P_ADDRESSED) cfg_reg.line_ctrl <= sel_hold_reg[7:5];
         end
         if (ring_s) cfg_reg.line_ctrl[2] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Slot counters and enables
   // ----------------------------------------------------------------
   logic [9:0] tx_pos_reg, rx_pos_reg, tx_pos_next, rx_pos_next;
   logic       tx_en_reg, rx_en_reg, hook_oe_reg;
   logic [5:0] tx_slot_next, rx_slot_next;
   logic       tx_on_next, rx_on_next, run_next;

   // Loads and enables share the frame sync edge so a new slot shows at once
   assign tx_slot_next = (accept && ld_tx) ? slot_hold_reg[5:0] : cfg_reg.tx_slot;
   assign rx_slot_next = (accept && ld_rx) ? slot_hold_reg[5:0] : cfg_reg.rx_slot;
   assign tx_on_next   = accept ? (ld_tx | (tx_on_reg & ld_rx)) : tx_on_reg;
   assign rx_on_next   = accept ? ((ld_tx | ld_rx) ? (rx_on_reg | ld_rx | P_ADDRESSED) :
                                   (!P_ADDRESSED & rx_on_reg)) : rx_on_reg;
   assign run_next     = accept ? ((ld_tx | ld_rx) | (!P_ADDRESSED & run_reg)) : run_reg;

   // Counters saturate so an over-long frame cannot wrap into a stale slot
   assign tx_pos_next = tx_fs_start ? TSA_POS_ZERO :
                        (tx_pos_reg == TSA_POS_MAX) ? tx_pos_reg : tx_pos_reg + 10'h001;
   assign rx_pos_next = rx_fs_start ? TSA_POS_ZERO :
                        (rx_pos_reg == TSA_POS_MAX) ? rx_pos_reg : rx_pos_reg + 10'h001;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tx_pos_reg  <= TSA_POS_MAX;
         tx_en_reg   <= 1'b0;
         hook_oe_reg <= 1'b0;
      end else if (dca_rise) begin
         tx_pos_reg  <= run_next ? tx_pos_next : TSA_POS_MAX;
         tx_en_reg   <= run_next & tx_on_next & tsa_slot_hit(tx_pos_next, tx_slot_next);
         hook_oe_reg <= !P_ADDRESSED & run_next & hook_s &
                        tsa_slot_hit(tx_pos_next, tx_slot_next);
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rx_pos_reg <= TSA_POS_MAX;
         rx_en_reg  <= 1'b0;
      end else if (rx_dc_rise) begin
         rx_pos_reg <= run_next ? rx_pos_next : TSA_POS_MAX;
         rx_en_reg  <= run_next & rx_on_next & tsa_slot_hit(rx_pos_next, rx_slot_next);
      end
   end

   // ----------------------------------------------------------------
   // Acknowledge sequencing
   // ----------------------------------------------------------------
   tsa_ack_t   ack_state_reg;
   logic [1:0] ack_cnt_reg;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_state_reg <= TSA_ACK_IDLE;
         ack_cnt_reg   <= 2'h0;
      end else if (tx_fs_start) begin
         ack_state_reg <= accept ? TSA_ACK_WAIT : TSA_ACK_IDLE;
         ack_cnt_reg   <= 2'h0;
      end else if (dca_rise) begin
         case (ack_state_reg)
            TSA_ACK_WAIT: begin
               if (ack_cnt_reg == TSA_ACK_LAST) ack_state_reg <= TSA_ACK_LOW;
               ack_cnt_reg <= ack_cnt_reg + 2'h1;
            end
            TSA_ACK_LOW:  ack_state_reg <= TSA_ACK_LOW;
            TSA_ACK_IDLE: ack_state_reg <= TSA_ACK_IDLE;
            default:      ack_state_reg <= TSA_ACK_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB slave: zero wait, read data registered in the setup cycle
   // ----------------------------------------------------------------
   logic        setup, wr_acc;
   logic [31:0] rdata_reg;
   logic        slverr_reg;
   logic        mapped;

   assign setup    = i_psel & ~i_penable;
   assign wr_acc   = i_psel & i_penable & i_pwrite;
   assign mapped   = (i_paddr == TSA_OFS_CTRL) || (i_paddr == TSA_OFS_STATUS) || (i_paddr == TSA_OFS_SLOTS);
   assign abort_wr = wr_acc & (i_paddr == TSA_OFS_CTRL) & i_pwdata[TSA_CTRL_ABORT_BIT];

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         port_en_reg <= TSA_PORT_EN_RST;
      end else if (wr_acc && i_paddr == TSA_OFS_CTRL) begin
         port_en_reg <= i_pwdata[TSA_CTRL_PORT_EN_BIT];
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_reg  <= 32'h0000_0000;
         slverr_reg <= 1'b0;
      end else if (setup) begin
         slverr_reg <= ~mapped;
         rdata_reg  <= 32'h0000_0000;
         if (!i_pwrite) begin
            case (i_paddr)
               TSA_OFS_CTRL:   rdata_reg <= {31'h0000_0000, port_en_reg};
               TSA_OFS_STATUS: rdata_reg <= {25'h000_0000, ack_state_reg, pd_reg, run_reg,
                                             rx_on_reg, tx_on_reg, pending_reg};
               TSA_OFS_SLOTS:  rdata_reg <= {13'h0000, cfg_reg.line_ctrl, 2'h0, cfg_reg.rx_slot,
                                             2'h0, cfg_reg.tx_slot};
               default:        rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_pready             = 1'b1;
   assign o_prdata             = rdata_reg;
   assign o_pslverr            = slverr_reg & i_psel & i_penable;
   assign o_accept_ack_o       = 1'b0;
   assign o_accept_ack_oe      = (ack_state_reg == TSA_ACK_LOW);
   assign o_tx_slot_enable     = tx_en_reg;
   assign o_rx_slot_enable     = rx_en_reg;
   assign o_line_control_bits  = cfg_reg.line_ctrl;
   assign o_power_down_out     = pd_reg;
   assign o_hook_status_out_o  = 1'b0;
   assign o_hook_status_out_oe = hook_oe_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_ack_armed;
      tx_fs_start && accept;
   endsequence
   sequence s_ack_low;
      ack_state_reg == TSA_ACK_LOW;
   endsequence

   AST_ACK_ARMS: assert property (s_ack_armed |=> ack_state_reg == TSA_ACK_WAIT && ack_cnt_reg == 2'h0)
      else $error("Accepted word did not arm the acknowledge");
   AST_ACK_THIRD: assert property ($rose(o_accept_ack_oe) |-> $past(dca_rise) && $past(ack_cnt_reg) == 2'h2)
      else $error("Acknowledge fell on the wrong data clock");
   AST_ACK_RELEASE: assert property (s_ack_low ##0 tx_fs_start |=> !o_accept_ack_oe)
      else $error("Acknowledge not released at frame sync");
   AST_ACK_NOMATCH: assert property (tx_fs_start && pending_reg && !id_match |=> ack_state_reg == TSA_ACK_IDLE)
      else $error("Unmatched unit acknowledged");
   AST_ACK_OPEN_DRAIN: assert property ($rose(o_accept_ack_oe) |-> $past(ack_state_reg) == TSA_ACK_WAIT && o_accept_ack_o == 1'b0)
      else $error("Acknowledge drives high");
   AST_FS_ZERO: assert property (tx_fs_start && run_next |=> tx_pos_reg == TSA_POS_ZERO)
      else $error("Frame sync did not restart the counter");
   AST_TX_IN_SLOT: assert property (o_tx_slot_enable |-> tsa_slot_hit(tx_pos_reg, cfg_reg.tx_slot) && tx_on_reg)
      else $error("Transmit enable outside its slot");
   AST_RX_IN_SLOT: assert property (o_rx_slot_enable |-> tsa_slot_hit(rx_pos_reg, cfg_reg.rx_slot) && rx_on_reg)
      else $error("Receive enable outside its slot");
   AST_LOAD_AT_FS: assert property ($changed(cfg_reg.tx_slot) |-> $past(accept))
      else $error("Slot register changed away from frame sync");
   AST_WORD_EIGHT: assert property ($rose(pending_reg) |-> $past(bit_cnt_reg) == TSA_WORD_LAST)
      else $error("Word pending before eight bits");
   AST_RING_CLEAR: assert property (ring_s |=> o_line_control_bits[2] == 1'b0)
      else $error("Ring clear did not force line bit two");
   AST_NOMATCH_KEEP: assert property (tx_fs_start && !accept |=> $stable(cfg_reg) || $past(ring_s))
      else $error("Configuration changed without acceptance");

endmodule : tsa_slot_assigner

/* tb/tsa_proc_model.sv */
// Purpose: Processor model driving the serial programming port
// Assumes: Serial clock period 125 ns, idle low between words
// Notes:   Released data lines show the inverse of their last value
module tsa_proc_model (
   // Serial port
   output logic o_serial_clk,
   output logic o_group_select,
   output logic o_slot_word,
   output logic o_select_word
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      o_serial_clk   = 1'b0;
      o_group_select = 1'b0;
      o_slot_word    = 1'b0;
      o_select_word  = 1'b0;
   end

   // Select stays high afterwards until the caller calls drop
   task automatic send(input logic [7:0] sw, input logic [7:0] aw);
      o_group_select = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         #62.5 o_serial_clk = 1'b1;
         o_slot_word   = sw[i];
         o_select_word = aw[i];
         #62.5 o_serial_clk = 1'b0;
      end
   endtask : send

   // Flip the lines so a stale bit cannot pass for valid data
   task automatic drop();
      o_group_select = 1'b0;
      o_slot_word    = ~o_slot_word;
      o_select_word  = ~o_select_word;
   endtask : drop
endmodule : tsa_proc_model

/* tb/testbench.sv */
// Purpose: Self-checking bench for the addressed slot assigner
// Assumes: 64-bit frames, data clock period 400 ns
// Notes:   Each frame's enable and acknowledge levels are sampled a quarter bit after the data clock rise
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; $display("BAD %0t mismatch", $time); end end
module testbench
   import tsa_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        i_clk, i_sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ring = 1'b0;
   logic        pready, pslverr, ack_oe, ack_o, pd, tx_en, rx_en, rerr, dca = 1'b0, fs = 1'b0;
   logic [4:0]  hwid = 5'h10;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [2:0]  line;
   logic [5:0]  div = '0, bitpos = '0;
   logic [63:0] txv = '0, rxv = '0, akv = '0, last_tx = '0, last_rx = '0, last_ack = '0;
   wire         sclk, gsel, sdat, adat;
   int          err_total = 0, n_checks = 0, frames = 0, cyc = 0;

   tsa_slot_assigner #(.P_ADDRESSED(1'b1)) tsa_slot_assigner_i (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .i_serial_clk(sclk), .i_group_select(gsel), .i_slot_word_in(sdat), .i_select_word_in(adat),
      .i_hardwired_id(hwid), .o_accept_ack_o(ack_o), .o_accept_ack_oe(ack_oe),
      .i_data_clock_a(dca), .i_data_clock_b(~dca), .i_tx_frame_sync(fs), .i_rx_frame_sync(fs),
      .o_tx_slot_enable(tx_en), .o_rx_slot_enable(rx_en), .i_ring_clear_input(ring),
      .i_hook_sense_in(1'b0), .o_line_control_bits(line), .o_power_down_out(pd),
      .o_hook_status_out_o(), .o_hook_status_out_oe());

   tsa_proc_model tsa_proc_model_i (
      .o_serial_clk(sclk), .o_group_select(gsel), .o_slot_word(sdat), .o_select_word(adat));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // Frame sync rises ahead of the bit 0 clock edge, within setup
   always @(posedge i_clk) begin
      div <= (div == 6'd39) ? 6'd0 : div + 6'd1;
      if (div == 6'd39) begin
         dca    <= 1'b1;
         bitpos <= bitpos + 6'd1;
      end
      if (div == 6'd19) dca <= 1'b0;
      if (div == 6'd30) fs <= (bitpos == 6'd63);
      if (div == 6'd10) begin
         txv[bitpos] <= tx_en;
         rxv[bitpos] <= rx_en;
         akv[bitpos] <= ack_oe;
         if (bitpos == 6'd63) begin
            last_tx  <= {tx_en, txv[62:0]};
            last_rx  <= {rx_en, rxv[62:0]};
            last_ack <= {ack_oe, akv[62:0]};
            frames   <= frames + 1;
         end
      end
   end

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge i_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge i_clk);
      penable <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rd   = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_frame();
      int f;
      f = frames;
      while (frames == f) @(posedge i_clk);
   endtask : wait_frame

   // Word goes in early in one frame; the next frame is the loading one
   task automatic load_word(input logic [7:0] sw, input logic [7:0] aw);
      wait_frame();
      repeat (100) @(posedge i_clk);
      tsa_proc_model_i.send(sw, aw);
      wait_frame();
      wait_frame();
      tsa_proc_model_i.drop();
   endtask : load_word

   task automatic t_regs();
      apb(1'b0, TSA_OFS_CTRL, 32'h0000_0000);
      `CHK(rd, 32'h0000_0001)
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      `CHK(rerr, 1'b1)
   endtask : t_regs

   task automatic t_both();
      load_word({2'b00, 6'h02}, {3'h3, 5'h10});
      `CHK(last_ack, 64'hFFFF_FFFF_FFFF_FFF8)
      `CHK(last_tx, 64'h0000_0000_00FF_0000)
      `CHK(last_rx, 64'h0000_0000_00FF_0000)
      `CHK(line, 3'h3)
      apb(1'b0, TSA_OFS_SLOTS, 32'h0000_0000);
      `CHK(rd, 32'h0003_0202)
      apb(1'b0, TSA_OFS_STATUS, 32'h0000_0000);
      `CHK(rd, 32'h0000_007E)
      `CHK(ack_o, 1'b0)
      wait_frame();
      `CHK(last_ack, 64'h0000_0000_0000_0000)
      `CHK(last_tx, 64'h0000_0000_00FF_0000)
   endtask : t_both

   task automatic t_rx_only();
      load_word({2'b10, 6'h05}, {3'h1, 5'h10});
      `CHK(last_rx, 64'h0000_FF00_0000_0000)
      `CHK(last_tx, 64'h0000_0000_00FF_0000)
      `CHK(line, 3'h1)
   endtask : t_rx_only

   task automatic t_mismatch();
      load_word({2'b00, 6'h07}, {3'h7, 5'h01});
      `CHK(last_ack, 64'h0000_0000_0000_0000)
      `CHK(last_tx, 64'h0000_0000_00FF_0000)
      `CHK(line, 3'h1)
   endtask : t_mismatch

   task automatic t_idle();
      ring <= 1'b1;
      load_word({2'b11, 6'h00}, {3'h7, 5'h10});
      `CHK(last_tx, 64'h0000_0000_0000_0000)
      `CHK(last_rx, 64'h0000_0000_0000_0000)
      `CHK(last_ack, 64'hFFFF_FFFF_FFFF_FFF8)
      `CHK(line, 3'h3)
      `CHK(pd, 1'b1)
      ring <= 1'b0;
   endtask : t_idle

   // New unit address on the pins, so the compare follows them
   task automatic t_tx_only();
      hwid <= 5'h06;
      load_word({2'b01, 6'h06}, {3'h6, 5'h06});
      `CHK(last_tx, 64'h00FF_0000_0000_0000)
      `CHK(last_rx, 64'h0000_FF00_0000_0000)
      `CHK(last_ack, 64'hFFFF_FFFF_FFFF_FFF8)
      `CHK(line, 3'h6)
   endtask : t_tx_only

   // Disabled port ignores a word; an aborted word never loads
   task automatic t_abort();
      apb(1'b1, TSA_OFS_CTRL, 32'h0000_0000);
      tsa_proc_model_i.send({2'b00, 6'h09}, {3'h5, 5'h06});
      repeat (5) @(posedge i_clk);
      apb(1'b0, TSA_OFS_STATUS, 32'h0000_0000);
      `CHK(rd[0], 1'b0)
      apb(1'b1, TSA_OFS_CTRL, 32'h0000_0001);
      tsa_proc_model_i.send({2'b00, 6'h09}, {3'h5, 5'h06});
      repeat (5) @(posedge i_clk);
      apb(1'b0, TSA_OFS_STATUS, 32'h0000_0000);
      `CHK(rd[0], 1'b1)
      apb(1'b1, TSA_OFS_CTRL, 32'h0000_0003);
      apb(1'b0, TSA_OFS_CTRL, 32'h0000_0000);
      `CHK(rd, 32'h0000_0001)
      apb(1'b0, TSA_OFS_STATUS, 32'h0000_0000);
      `CHK(rd[0], 1'b0)
      wait_frame();
      wait_frame();
      tsa_proc_model_i.drop();
      `CHK(last_ack, 64'h0000_0000_0000_0000)
      `CHK(last_tx, 64'h00FF_0000_0000_0000)
   endtask : t_abort

   initial begin
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_regs();
      t_both();
      t_rx_only();
      t_mismatch();
      t_idle();
      t_tx_only();
      t_abort();
      complete_run();
   end
endmodule : testbench
